// ### logic/ppufc_top.sv
// configuration bank for parallel-port mode, serial music clocks and floppy setup
// assumes one clock, inputs synchronous to it, host access through an index register
`timescale 1ns/1ps
`include "ppufc_regs.svh"
module ppufc_top #(
   parameter int CLK_HZ = `PPUFC_CLK_HZ,
   parameter int MUSIC_DIV = `PPUFC_MUSIC_DIV
) (
   input wire logic clock,
   input wire logic nrst,
   input wire ppufc_pkg::ppufc_cfg_type cfg,
   output logic [7:0] rdata,
   output logic rvalid,
   input wire logic cfg_one_bit3,
   input wire logic ecr_wr,
   input wire logic [2:0] ecr_mode,
   output ppufc_pkg::ppufc_op_type pp_op,
   output logic pp_floppy_variant_one,
   output logic pp_floppy_variant_two,
   output logic serial_one_music_clock,
   output logic serial_two_music_clock,
   output logic serial_one_baud_tick,
   output logic serial_two_baud_tick,
   output logic epp_v17,
   output logic fdc_dma_nonburst,
   input wire logic drive_density_one_force,
   input wire ppufc_pkg::ppufc_fdd_type fdc_core,
   output ppufc_pkg::ppufc_fdd_type fdd_pin_out,
   output ppufc_pkg::ppufc_fdd_type fdd_pin_oe,
   output ppufc_pkg::ppufc_fdd_type pp_fdd_out
);
   import ppufc_pkg::*;

   // the divider must fit and the music rate must land within one percent
   localparam int REAL_BAUD = CLK_HZ / (MUSIC_DIV * `PPUFC_OVERSAMPLE);
   localparam int BAUD_ERR = (REAL_BAUD > `PPUFC_MUSIC_BAUD) ?
      REAL_BAUD - `PPUFC_MUSIC_BAUD : `PPUFC_MUSIC_BAUD - REAL_BAUD;
   if (MUSIC_DIV < 2 || MUSIC_DIV >= (1 << `PPUFC_DIV_W) ||
       BAUD_ERR * 100 > `PPUFC_MUSIC_BAUD) begin : g_bad_divider
      $error("ppufc_top: music divider out of range");
   end

   localparam logic [`PPUFC_DIV_W-1:0] DIV_LAST = `PPUFC_DIV_W'(MUSIC_DIV - 1);

   logic rst_meta;
   logic rst_n;
   ppufc_state_type state;
   ppufc_state_type next_state;

   // reset released through two flops, asserted at once
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // open-drain only pulls low, push-pull drives both levels
   function automatic logic pin_enable(input logic v, input logic push, input logic flt);
      pin_enable = !flt && (push || !v);
   endfunction

   function automatic logic pin_level(input logic v, input logic push);
      pin_level = push ? v : 1'b0;
   endfunction

   logic [1:0] mode_f;
   logic [1:0] den_f;
   logic flt;
   logic push;
   ppufc_fdd_type drv;

   assign mode_f = state.misc[`PPUFC_MODE_LSB +: 2];
   assign den_f = state.fsetup[`PPUFC_DEN_LSB +: 2];
   assign flt = state.fsetup[`PPUFC_FLOAT_BIT];
   assign push = state.fsetup[`PPUFC_OTYPE_BIT];

   // next state: register access, parallel mode tracking, music divider, pins
   always_comb begin
      next_state = state;
      next_state.rvalid = 1'b0;
      drv = fdc_core;
      // host access only counts in the configuration state
      if (cfg.cfg_state && cfg.index_wr) begin
         next_state.index = cfg.wdata;
      end else if (cfg.cfg_state && cfg.data_wr) begin
         if (state.index == `PPUFC_IDX_MISC) begin
            next_state.misc = cfg.wdata & `PPUFC_MISC_RD_MASK;
            // a new mode restarts the port in its base operation
            if (cfg.wdata[`PPUFC_MODE_LSB +: 2] != mode_f) begin
               case (cfg.wdata[`PPUFC_MODE_LSB +: 2])
                  2'h0: next_state.pp_op = PPUFC_OP_SPP;
                  2'h1: next_state.pp_op = PPUFC_OP_EPP;
                  default: next_state.pp_op = PPUFC_OP_ECP;
               endcase
            end
         end else if (state.index == `PPUFC_IDX_FSETUP) begin
            next_state.fsetup = cfg.wdata & `PPUFC_FSETUP_RD_MASK;
         end
      end else if (ecr_wr && mode_f[1]) begin
         // extended control writes steer the ECP-capable settings
         if (ecr_mode == `PPUFC_ECR_SPP) begin
            next_state.pp_op = PPUFC_OP_SPP;
         end else if (ecr_mode == `PPUFC_ECR_EPP && mode_f[0]) begin
            next_state.pp_op = PPUFC_OP_EPP;
         end else begin
            next_state.pp_op = PPUFC_OP_ECP;
         end
      end
      // unmapped indices read zero; reserved bits are stored as zero
      if (cfg.cfg_state && cfg.data_rd) begin
         next_state.rvalid = 1'b1;
         if (state.index == `PPUFC_IDX_MISC) begin
            next_state.rdata = state.misc;
         end else if (state.index == `PPUFC_IDX_FSETUP) begin
            next_state.rdata = state.fsetup;
         end else begin
            next_state.rdata = 8'h00;
         end
      end
      // one shared divider; ticks at 16x the music rate
      next_state.div = (state.div == DIV_LAST) ? '0 : state.div + 1'b1;
      next_state.tick1 = (state.div == DIV_LAST) && state.misc[`PPUFC_MUSIC1_BIT];
      next_state.tick2 = (state.div == DIV_LAST) && state.misc[`PPUFC_MUSIC2_BIT];
      // density select forcing; reserved code behaves as normal
      case (den_f)
         2'h2: drv.density = 1'b1;
         2'h3: drv.density = 1'b0;
         default: drv.density = fdc_core.density;
      endcase
      if (drive_density_one_force) begin
         drv.density_one = 1'b1;
      end
      next_state.pin_out.drive_sel0 = pin_level(drv.drive_sel0, push);
      next_state.pin_out.drive_sel1 = pin_level(drv.drive_sel1, push);
      next_state.pin_out.motor0 = pin_level(drv.motor0, push);
      next_state.pin_out.motor1 = pin_level(drv.motor1, push);
      next_state.pin_out.density = pin_level(drv.density, push);
      next_state.pin_out.density_one = pin_level(drv.density_one, push);
      next_state.pin_oe.drive_sel0 = pin_enable(drv.drive_sel0, push, flt);
      next_state.pin_oe.drive_sel1 = pin_enable(drv.drive_sel1, push, flt);
      next_state.pin_oe.motor0 = pin_enable(drv.motor0, push, flt);
      next_state.pin_oe.motor1 = pin_enable(drv.motor1, push, flt);
      next_state.pin_oe.density = pin_enable(drv.density, push, flt);
      next_state.pin_oe.density_one = pin_enable(drv.density_one, push, flt);
      // parallel-port floppy path ignores type and float, honours swap
      next_state.pp_fdd = drv;
      if (state.fsetup[`PPUFC_SWAP_BIT]) begin
         next_state.pp_fdd.drive_sel0 = drv.drive_sel1;
         next_state.pp_fdd.drive_sel1 = drv.drive_sel0;
         next_state.pp_fdd.motor0 = drv.motor1;
         next_state.pp_fdd.motor1 = drv.motor0;
      end
   end

   // single state register; all of it clears to zero except pp_op, which starts in SPP
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
         state.pp_op <= PPUFC_OP_SPP;
      end else begin
         state <= next_state;
      end
   end

   // outputs from state; pp_op forced to SPP while cfg_one_bit3 is high
   assign rdata = state.rdata;
   assign rvalid = state.rvalid;
   assign pp_op = cfg_one_bit3 ? PPUFC_OP_SPP : state.pp_op;
   assign pp_floppy_variant_one = state.misc[`PPUFC_PPFD_LSB +: 2] == 2'h1;
   assign pp_floppy_variant_two = state.misc[`PPUFC_PPFD_LSB +: 2] == 2'h2;
   assign serial_one_music_clock = state.misc[`PPUFC_MUSIC1_BIT];
   assign serial_two_music_clock = state.misc[`PPUFC_MUSIC2_BIT];
   assign serial_one_baud_tick = state.tick1;
   assign serial_two_baud_tick = state.tick2;
   assign epp_v17 = state.misc[`PPUFC_EPPTYPE_BIT];
   assign fdc_dma_nonburst = state.fsetup[`PPUFC_DMA_BIT];
   assign fdd_pin_out = state.pin_out;
   assign fdd_pin_oe = state.pin_oe;
   assign pp_fdd_out = state.pp_fdd;

   // helper: cycles since the previous port-one tick
   logic [`PPUFC_DIV_W-1:0] since_tick;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         since_tick <= '0;
      end else begin
         since_tick <= state.tick1 ? '0 : since_tick + 1'b1;
      end
   end
   logic seen_tick;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         seen_tick <= 1'b0;
      end else if (state.tick1) begin
         seen_tick <= 1'b1;
      end else if (!state.misc[`PPUFC_MUSIC1_BIT]) begin
         seen_tick <= 1'b0;
      end
   end

   // port-two twin of the spacing helper
   logic [`PPUFC_DIV_W-1:0] since_tick2;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         since_tick2 <= '0;
      end else begin
         since_tick2 <= state.tick2 ? '0 : since_tick2 + 1'b1;
      end
   end
   logic seen_tick2;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         seen_tick2 <= 1'b0;
      end else if (state.tick2) begin
         seen_tick2 <= 1'b1;
      end else if (!state.misc[`PPUFC_MUSIC2_BIT]) begin
         seen_tick2 <= 1'b0;
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);

   // host port: answers, refusals, read-back masks; reads use the previous index
   a_read_answered: assert property (cfg.cfg_state && cfg.data_rd |=> rvalid)
      else $error("read strobe got no answer");
   a_read_refused: assert property (!cfg.cfg_state |=> !rvalid)
      else $error("read answered outside the configuration state");
   a_rdata_holds: assert property (!rvalid |-> $stable(rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (rvalid && $past(state.index) != `PPUFC_IDX_MISC
      && $past(state.index) != `PPUFC_IDX_FSETUP |-> rdata == 8'h00)
      else $error("unmapped index read nonzero");
   a_misc_bit7_zero: assert property (rvalid
      && $past(state.index) == `PPUFC_IDX_MISC |-> !rdata[7])
      else $error("misc register bit 7 read as one");
   a_fsetup_top_zero: assert property (rvalid
      && $past(state.index) == `PPUFC_IDX_FSETUP |-> rdata[7:6] == 2'h0)
      else $error("floppy setup bits 7:6 read as nonzero");

   // parallel mode: one-hot state, override, mode writes, extended control
   a_op_onehot: assert property ($onehot(pp_op))
      else $error("parallel mode not one-hot");
   a_spp_override: assert property (cfg_one_bit3 |-> pp_op == PPUFC_OP_SPP)
      else $error("config register one bit 3 did not force SPP");
   a_mode_to_epp: assert property (cfg.cfg_state && cfg.data_wr && !cfg.index_wr
      && state.index == `PPUFC_IDX_MISC && cfg.wdata[`PPUFC_MODE_LSB +: 2] == 2'h1
      && mode_f != 2'h1 |=> state.pp_op == PPUFC_OP_EPP)
      else $error("mode 01 did not give EPP");
   a_ecr_ignored: assert property (ecr_wr && !mode_f[1]
      && !(cfg.cfg_state && (cfg.data_wr || cfg.index_wr))
      |=> state.pp_op == $past(state.pp_op))
      else $error("extended control write honoured in a non-ECP mode");
   a_ecr_enter_spp: assert property (ecr_wr && ecr_mode == `PPUFC_ECR_SPP && mode_f[1]
      && !cfg.data_wr && !cfg.index_wr && !cfg_one_bit3 ##1 !cfg_one_bit3
      |-> pp_op == PPUFC_OP_SPP)
      else $error("extended control 000 did not give SPP");
   a_ecr_enter_epp: assert property (ecr_wr && ecr_mode == `PPUFC_ECR_EPP
      && mode_f == 2'h3 && !cfg.data_wr && !cfg.index_wr |=> state.pp_op == PPUFC_OP_EPP)
      else $error("extended control 100 did not give EPP");
   a_ppfd_reserved: assert property (state.misc[`PPUFC_PPFD_LSB +: 2] == 2'h3
      |-> !pp_floppy_variant_one && !pp_floppy_variant_two)
      else $error("reserved floppy mapping code selected a variant");

   // music clocks: gating and tick spacing on both ports
   a_tick1_gated: assert property (serial_one_baud_tick
      |-> $past(serial_one_music_clock))
      else $error("port one tick without its music clock");
   a_tick2_gated: assert property (serial_two_baud_tick
      |-> $past(serial_two_music_clock))
      else $error("port two tick without its music clock");
   a_music_period: assert property (state.tick1 && seen_tick |-> since_tick == DIV_LAST)
      else $error("music tick spacing wrong");
   a_music2_period: assert property (state.tick2 && seen_tick2 |-> since_tick2 == DIV_LAST)
      else $error("port two music tick spacing wrong");

   // floppy pins and the parallel-port floppy path
   a_float_all_pins: assert property (flt && $stable(state.fsetup) |=> fdd_pin_oe == '0)
      else $error("floppy pin driven while floating");
   a_opendrain_no_high: assert property (!push && !flt
      |=> (fdd_pin_oe & fdd_pin_out) == '0)
      else $error("open-drain pin driven high");
   a_pushpull_on: assert property (push && !flt |=> fdd_pin_oe == 6'h3F)
      else $error("push-pull pin not driven");
   a_density_forced: assert property (den_f == 2'h2 && push && !flt
      && $stable(state.fsetup) |=> fdd_pin_out.density && fdd_pin_oe.density)
      else $error("density not forced high");
   a_density_low: assert property (den_f == 2'h3 && !flt
      |=> !fdd_pin_out.density && fdd_pin_oe.density)
      else $error("density not forced low");
   a_dd1_high: assert property (drive_density_one_force && !flt
      && $stable(state.fsetup) |=> !(fdd_pin_oe.density_one && !fdd_pin_out.density_one))
      else $error("density-one pin pulled low while forced high");
   a_dd1_normal: assert property (!drive_density_one_force && push && !flt
      |=> fdd_pin_out.density_one == $past(fdc_core.density_one))
      else $error("density-one pin lost its normal value");
   a_pp_passthrough: assert property (!state.fsetup[`PPUFC_SWAP_BIT] && !den_f[1]
      && !drive_density_one_force |=> pp_fdd_out == $past(fdc_core))
      else $error("parallel-port floppy path altered");
   a_pp_swap: assert property (state.fsetup[`PPUFC_SWAP_BIT]
      |=> pp_fdd_out.drive_sel0 == $past(fdc_core.drive_sel1)
      && pp_fdd_out.motor1 == $past(fdc_core.motor0))
      else $error("parallel-port drive swap missing");
endmodule

// ### logic/ppufc_regs.svh
// offsets, field positions, reset values and timing counts of the config bank
// assumes inclusion by the package, the bank module and the bench
// Function
// - parallel mode field selects SPP/EPP/ECP combinations
// - combined mode: extended control 100 enters EPP
// - ECP modes: extended control 000 enters SPP
// - bits 3:2 pick parallel-port floppy mapping
// - bit 4 selects port one music clock
// - bit 5 selects port two music clock
// - music clock gives 31.25 kilobaud within one percent
// - bit 6 picks EPP 1.7, else 1.9
// - misc register bit 7 reads zero
// - both registers clear to zero on reset
// - floppy setup bit 0: push-pull, else open-drain
// - floppy setup bit 1 floats floppy outputs
// - floppy setup bit 2 picks non-burst DMA
// - bit 5 swaps drive/motor selects on parallel port
// - floppy setup bits 7:6 read zero
// - output type and float skip parallel-port floppy
// - density-one pin normal, forced high, or floating
`ifndef PPUFC_REGS_SVH
`define PPUFC_REGS_SVH

`define PPUFC_IDX_MISC 8'h04
`define PPUFC_IDX_FSETUP 8'h05
`define PPUFC_RST_VAL 8'h00
`define PPUFC_MISC_RD_MASK 8'h7F
`define PPUFC_FSETUP_RD_MASK 8'h3F

`define PPUFC_MODE_LSB 0
`define PPUFC_PPFD_LSB 2
`define PPUFC_MUSIC1_BIT 4
`define PPUFC_MUSIC2_BIT 5
`define PPUFC_EPPTYPE_BIT 6
`define PPUFC_OTYPE_BIT 0
`define PPUFC_FLOAT_BIT 1
`define PPUFC_DMA_BIT 2
`define PPUFC_DEN_LSB 3
`define PPUFC_SWAP_BIT 5

`define PPUFC_ECR_SPP 3'h0
`define PPUFC_ECR_EPP 3'h4

`define PPUFC_CLK_HZ 250000000
`define PPUFC_MUSIC_BAUD 31250
`define PPUFC_OVERSAMPLE 16
`define PPUFC_MUSIC_DIV (`PPUFC_CLK_HZ / (`PPUFC_MUSIC_BAUD * `PPUFC_OVERSAMPLE))
`define PPUFC_DIV_W 12

`endif

// ### logic/ppufc_pkg.sv
// types of the parallel/serial/floppy configuration bank
// assumes the constants header sits beside it
package ppufc_pkg;
`include "ppufc_regs.svh"

   // parallel-port operating state, one-hot
   typedef enum logic [2:0] {
      PPUFC_OP_SPP = 3'h1,
      PPUFC_OP_EPP = 3'h2,
      PPUFC_OP_ECP = 3'h4
   } ppufc_op_type;

   // configuration port access, one cycle strobes
   typedef struct packed {
      logic cfg_state;
      logic index_wr;
      logic data_wr;
      logic data_rd;
      logic [7:0] wdata;
   } ppufc_cfg_type;

   // floppy output group
   typedef struct packed {
      logic drive_sel0;
      logic drive_sel1;
      logic motor0;
      logic motor1;
      logic density;
      logic density_one;
   } ppufc_fdd_type;

   // whole state of the bank
   typedef struct packed {
      logic [7:0] index;
      logic [7:0] misc;
      logic [7:0] fsetup;
      logic [7:0] rdata;
      logic rvalid;
      ppufc_op_type pp_op;
      logic [`PPUFC_DIV_W-1:0] div;
      logic tick1;
      logic tick2;
      ppufc_fdd_type pin_out;
      ppufc_fdd_type pin_oe;
      ppufc_fdd_type pp_fdd;
   } ppufc_state_type;
endpackage

// ### verif/pp_uart_fdc_misc_config_tb_top.sv
// self-checking bench of the parallel/serial/floppy configuration bank
// assumes the logic files compiled first and their header on the include path
`timescale 1ns/1ps
`include "ppufc_regs.svh"
module pp_uart_fdc_misc_config_tb_top;
   import ppufc_pkg::*;
   localparam int DIV = 10;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   ppufc_cfg_type cfg = '0;
   logic cfg_one_bit3 = 1'b0;
   logic ecr_wr = 1'b0;
   logic [2:0] ecr_mode = 3'h0;
   logic force_one = 1'b0;
   ppufc_fdd_type fdc_core = '0;
   logic [7:0] rdata;
   logic rvalid, music1, music2, tick1, tick2, v1, v2, epp_v17, nonburst;
   ppufc_op_type pp_op;
   ppufc_fdd_type pin_out, pin_oe, pp_fdd;
   int n_fail = 0;
   int check_count = 0;
   int n;

   // short divider keeps the baud check brief; clock scaled to match
   ppufc_top #(.CLK_HZ(DIV * 16 * 31250), .MUSIC_DIV(DIV)) i_dut (
      .clock(clock), .nrst(nrst), .cfg(cfg), .rdata(rdata), .rvalid(rvalid),
      .cfg_one_bit3(cfg_one_bit3), .ecr_wr(ecr_wr), .ecr_mode(ecr_mode), .pp_op(pp_op),
      .pp_floppy_variant_one(v1), .pp_floppy_variant_two(v2),
      .serial_one_music_clock(music1), .serial_two_music_clock(music2),
      .serial_one_baud_tick(tick1), .serial_two_baud_tick(tick2), .epp_v17(epp_v17),
      .fdc_dma_nonburst(nonburst), .drive_density_one_force(force_one),
      .fdc_core(fdc_core), .fdd_pin_out(pin_out), .fdd_pin_oe(pin_oe), .pp_fdd_out(pp_fdd));

   // 250 MHz clock
   initial begin
      forever #2 clock = ~clock;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // index write; strobes rise and fall on falling edges
   task automatic sel(input logic [7:0] idx);
      @(negedge clock);
      cfg.index_wr = 1'b1;
      cfg.wdata = idx;
      @(negedge clock);
      cfg.index_wr = 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      sel(idx);
      cfg.data_wr = 1'b1;
      cfg.wdata = v;
      @(negedge clock);
      cfg.data_wr = 1'b0;
      repeat (2) @(negedge clock);
   endtask

   // bounded wait for the read answer
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      sel(idx);
      cfg.data_rd = 1'b1;
      @(negedge clock);
      cfg.data_rd = 1'b0;
      for (int i = 0; i < 3 && rvalid !== 1'b1; i++) @(negedge clock);
      chk({7'h0, rvalid}, 8'h01);
      chk(rdata, exp);
   endtask

   task automatic ecr(input logic [2:0] m, input logic [7:0] exp);
      @(negedge clock);
      ecr_wr = 1'b1;
      ecr_mode = m;
      @(negedge clock);
      ecr_wr = 1'b0;
      repeat (2) @(negedge clock);
      chk({5'h0, pp_op}, exp);
   endtask

   // floppy setup, core values, expected pins; out unchecked when floated, FF skips pp
   task automatic fp(input logic [7:0] fs, input logic [5:0] core, input logic [7:0] eo,
                     input logic [7:0] eoe, input logic [7:0] ep);
      wr(`PPUFC_IDX_FSETUP, fs);
      fdc_core = core;
      repeat (2) @(negedge clock);
      if (!fs[1]) chk({2'h0, pin_out}, eo);
      chk({2'h0, pin_oe}, eoe);
      if (ep !== 8'hFF) chk({2'h0, pp_fdd}, ep);
   endtask

   // watchdog well beyond the expected run
   initial begin
      #40000;
      n_fail++;
      wrap_up();
   end

   initial begin
      repeat (3) @(negedge clock);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      chk({5'h0, pp_op}, 8'h01);
      cfg.cfg_state = 1'b1;
      rd(`PPUFC_IDX_MISC, 8'h00);
      rd(`PPUFC_IDX_FSETUP, 8'h00);
      // mode i with floppy mapping i, one write each
      for (int i = 0; i < 4; i++) begin
         wr(`PPUFC_IDX_MISC, 8'(i * 5));
         chk({5'h0, pp_op}, (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : 8'h04);
         chk({6'h0, v2, v1}, (i == 3) ? 8'h00 : 8'(i));
      end
      cfg_one_bit3 = 1'b1;
      repeat (2) @(negedge clock);
      chk({5'h0, pp_op}, 8'h01);
      cfg_one_bit3 = 1'b0;
      ecr(3'h4, 8'h02);
      ecr(3'h0, 8'h01);
      wr(`PPUFC_IDX_MISC, 8'h02);
      ecr(3'h0, 8'h01);
      wr(`PPUFC_IDX_MISC, 8'h01);
      ecr(3'h0, 8'h02);
      wr(`PPUFC_IDX_MISC, 8'hFF);
      rd(`PPUFC_IDX_MISC, 8'h7F);
      chk({5'h0, epp_v17, music2, music1}, 8'h07);
      wr(`PPUFC_IDX_MISC, 8'h00);
      chk({5'h0, epp_v17, music2, music1}, 8'h00);
      // strobes outside the configuration state must not land
      cfg.cfg_state = 1'b0;
      wr(`PPUFC_IDX_MISC, 8'h40);
      cfg.cfg_state = 1'b1;
      rd(`PPUFC_IDX_MISC, 8'h00);
      rd(8'h07, 8'h00);
      // port one music clock: tick spacing equals the divider
      wr(`PPUFC_IDX_MISC, 8'h10);
      for (int i = 0; i < DIV + 5 && tick1 !== 1'b1; i++) @(negedge clock);
      n = 0;
      @(negedge clock);
      for (int i = 0; i < DIV + 5 && tick1 !== 1'b1; i++) begin
         n++;
         chk({7'h0, tick2}, 8'h00);
         @(negedge clock);
      end
      chk(8'(n + 1), 8'(DIV));
      wr(`PPUFC_IDX_FSETUP, 8'hFF);
      rd(`PPUFC_IDX_FSETUP, 8'h3F);
      chk({7'h0, nonburst}, 8'h01);
      fp(8'h00, 6'h2A, 8'h00, 8'h15, 8'h2A);
      fp(8'h01, 6'h2A, 8'h2A, 8'h3F, 8'h2A);
      fp(8'h02, 6'h2A, 8'h00, 8'h00, 8'h2A);
      fp(8'h20, 6'h24, 8'h00, 8'h1B, 8'h18);
      fp(8'h11, 6'h00, 8'h02, 8'h3F, 8'hFF);
      fp(8'h19, 6'h3F, 8'h3D, 8'h3F, 8'hFF);
      fp(8'h09, 6'h3F, 8'h3F, 8'h3F, 8'hFF);
      force_one = 1'b1;
      fp(8'h01, 6'h00, 8'h01, 8'h3F, 8'hFF);
      fp(8'h03, 6'h00, 8'h00, 8'h00, 8'hFF);
      // port two ticks, then a mid-run reset must clear everything again
      wr(`PPUFC_IDX_MISC, 8'h7F);
      for (int i = 0; i < DIV + 5 && tick2 !== 1'b1; i++) @(negedge clock);
      chk({7'h0, tick2}, 8'h01);
      nrst = 1'b0;
      repeat (3) @(negedge clock);
      chk({5'h0, pp_op}, 8'h01);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      chk({5'h0, epp_v17, music2, music1}, 8'h00);
      rd(`PPUFC_IDX_MISC, 8'h00);
      rd(`PPUFC_IDX_FSETUP, 8'h00);
      wrap_up();
   end
endmodule
